// file: test/tlr_peer.sv
// Other instrument sharing the trigger line
`timescale 1ns/1ns
module tlr_peer (
	input wire logic assert_in,
	input wire logic dev_oe_in,
	output logic     line_out
);
	// Wired OR: the line is true while any party asserts it
	assign line_out = assert_in | dev_oe_in;
endmodule

// file: test/tlr_router_props.sv
// Port checks of the trigger line router
`timescale 1ns/1ns
module tlr_router_props (
	// Clock and reset
	input wire logic       clock_in,
	input wire logic       rst_n_in,
	// Configuration
	input wire logic       cfg_load_in,
	input wire logic [1:0] drive_sel_in,
	input wire logic [1:0] recv_sel_in,
	input wire logic [1:0] drive_sel_out,
	input wire logic [1:0] recv_sel_out,
	// Shared trigger line
	input wire logic       shared_trig_in,
	input wire logic       shared_trig_out,
	input wire logic       shared_trig_oe_out,
	// Internal triggers
	input wire logic       internal_trigger_a_in,
	input wire logic       internal_trigger_a_out,
	input wire logic       internal_trigger_a_oe_out,
	input wire logic       internal_trigger_b_in,
	input wire logic       internal_trigger_b_out,
	input wire logic       internal_trigger_b_oe_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	AST_LOAD: assert property (cfg_load_in |=> drive_sel_out ==
		$past(drive_sel_in) && recv_sel_out == $past(recv_sel_in)) else $error("load");
	AST_DA: assert property (drive_sel_out[0] && shared_trig_in |=>
		internal_trigger_a_out) else $error("drive a");
	AST_DB: assert property (drive_sel_out[1] && shared_trig_in |=>
		internal_trigger_b_oe_out) else $error("drive b");
	AST_DN: assert property (drive_sel_out == 2'h0 |=>
		!internal_trigger_a_oe_out && !internal_trigger_b_out) else $error("drive none");
	AST_RA: assert property (recv_sel_out == 2'h1 |=>
		shared_trig_oe_out == $past(internal_trigger_a_in)) else $error("recv a");
	AST_RB: assert property (recv_sel_out == 2'h2 |=>
		shared_trig_out == $past(internal_trigger_b_in)) else $error("recv b");
	AST_RAND: assert property (recv_sel_out == 2'h3 &&
		internal_trigger_a_in != internal_trigger_b_in |=> !shared_trig_oe_out)
		else $error("recv and");
	AST_RBOTH: assert property (recv_sel_out == 2'h3 &&
		internal_trigger_a_in && internal_trigger_b_in |=>
		shared_trig_out) else $error("recv both");
	AST_RN: assert property (recv_sel_out == 2'h0 |=> !shared_trig_out)
		else $error("recv none");
endmodule

// file: test/tlr_router_tb_top.sv
// Testbench of the trigger line router
`timescale 1ns/1ns
module tlr_router_tb_top;
	logic       clock_in = 0, rst_n_in = 0, ld = 0, peer = 0, ta = 0, tb = 0;
	logic [1:0] ds = 0, rs = 0, d_o, r_o;
	logic       line, s_o, s_oe, a_i, a_o, a_oe, b_i, b_o, b_oe;
	int         num_errors = 0, checks = 0, cyc = 0;
	always #25 clock_in = ~clock_in;
	// Internal trigger wires are wired OR of bench and router
	assign a_i = ta | a_oe;
	assign b_i = tb | b_oe;
	tlr_peer PEER (.assert_in(peer), .dev_oe_in(s_oe), .line_out(line));
	tlr_router DUT (.clock_in, .rst_n_in, .cfg_load_in(ld),
		.drive_sel_in(ds), .recv_sel_in(rs), .drive_sel_out(d_o),
		.recv_sel_out(r_o), .shared_trig_in(line), .shared_trig_out(s_o),
		.shared_trig_oe_out(s_oe), .internal_trigger_a_in(a_i),
		.internal_trigger_a_out(a_o), .internal_trigger_a_oe_out(a_oe),
		.internal_trigger_b_in(b_i), .internal_trigger_b_out(b_o),
		.internal_trigger_b_oe_out(b_oe));
	task automatic cmp(string nm, logic [1:0] e, logic [1:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cfg(logic [1:0] d, logic [1:0] r);
		@(negedge clock_in);
		{ld, ds, rs} = {1'h1, d, r};
		@(negedge clock_in);
		ld = 0;
	endtask
	task close_out;
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 500) begin
			num_errors++;
			close_out;
		end
	end
	initial begin
		repeat (10) @(negedge clock_in);
		rst_n_in = 1;
		{peer, ta, tb} = 3'h7;
		repeat (2) @(negedge clock_in);
		cmp("sel", 2'h0, d_o | r_o);
		cmp("drv", 2'h0, {b_o, a_o});
		cmp("line", 2'h0, {s_o, s_oe});
		{peer, ta, tb} = 3'h0;
		for (int d = 1; d < 4; d++) begin
			cfg(d[1:0], 2'h0);
			cmp("dsel", d[1:0], d_o);
			cmp("rsel", 2'h0, r_o);
			peer = 1;
			@(negedge clock_in);
			cmp("drv", d[1:0], {b_oe, a_o});
			peer = 0;
			@(negedge clock_in);
			cmp("drv", 2'h0, {b_o, a_oe});
		end
		for (int r = 1; r < 4; r++) begin
			cfg(2'h0, r[1:0]);
			cmp("rsel", r[1:0], r_o);
			for (int t = 0; t < 4; t++) begin
				{tb, ta} = t[1:0];
				@(negedge clock_in);
				cmp("line", {2{(t[1:0] & r[1:0]) == r[1:0]}}, {s_o, s_oe});
			end
		end
		rst_n_in = 0;
		@(negedge clock_in);
		rst_n_in = 1;
		@(negedge clock_in);
		cmp("sel", 2'h0, d_o | r_o);
		close_out;
	end
endmodule
bind tlr_router tlr_router_props PROPS (
	.clock_in                  (clock_in),
	.rst_n_in                  (rst_n_in),
	.cfg_load_in               (cfg_load_in),
	.drive_sel_in              (drive_sel_in),
	.recv_sel_in               (recv_sel_in),
	.drive_sel_out             (drive_sel_out),
	.recv_sel_out              (recv_sel_out),
	.shared_trig_in            (shared_trig_in),
	.shared_trig_out           (shared_trig_out),
	.shared_trig_oe_out        (shared_trig_oe_out),
	.internal_trigger_a_in     (internal_trigger_a_in),
	.internal_trigger_a_out    (internal_trigger_a_out),
	.internal_trigger_a_oe_out (internal_trigger_a_oe_out),
	.internal_trigger_b_in     (internal_trigger_b_in),
	.internal_trigger_b_out    (internal_trigger_b_out),
	.internal_trigger_b_oe_out (internal_trigger_b_oe_out)
);

// file: verilog/tlr_lane.sv
// One internal trigger lane: drive and receive terms for one trigger
`timescale 1ns/1ns
module tlr_lane (
	// Lane connection
	tlr_lane_if.lane lane_if
);

	// ========================================
	// Drive term
	// A deselected lane ignores the shared line entirely
	assign lane_if.trig_drive = lane_if.drive_en & lane_if.line_rx;

	// ========================================
	// Receive term
	// A deselected lane passes true so it never blocks the AND
	assign lane_if.recv_ok = lane_if.trig_rx | ~lane_if.recv_en;

endmodule

// file: verilog/tlr_lane_if.sv
// Interface between the router core and one internal trigger lane
`timescale 1ns/1ns
interface tlr_lane_if;

	logic drive_en;
	logic recv_en;
	logic line_rx;
	logic trig_rx;
	logic trig_drive;
	logic recv_ok;

	modport core (
		output drive_en,
		output recv_en,
		output line_rx,
		output trig_rx,
		input  trig_drive,
		input  recv_ok
	);

	modport lane (
		input  drive_en,
		input  recv_en,
		input  line_rx,
		input  trig_rx,
		output trig_drive,
		output recv_ok
	);

endinterface

// file: verilog/tlr_pkg.sv
// Package of constants for the trigger line router
package tlr_pkg;

	// ========================================
	// Selection layout
	localparam int unsigned   SEL_W     = 2;
	localparam int unsigned   LANE_A    = 0;
	localparam int unsigned   LANE_B    = 1;

	// ========================================
	// Selection codes and values after reset
	localparam logic [SEL_W-1:0] SEL_NONE = 2'h0;
	localparam logic [SEL_W-1:0] SEL_A    = 2'h1;
	localparam logic [SEL_W-1:0] SEL_B    = 2'h2;
	localparam logic [SEL_W-1:0] SEL_BOTH = 2'h3;
	localparam logic             TRIG_RST = 1'h0;

endpackage

// file: verilog/tlr_router.sv
// Router between the shared trigger line and two internal triggers
`timescale 1ns/1ns
module tlr_router (
	// Clock and reset
	input  wire logic                      clock_in,
	input  wire logic                      rst_n_in,

	// Configuration
	input  wire logic                      cfg_load_in,
	input  wire logic [tlr_pkg::SEL_W-1:0] drive_sel_in,
	input  wire logic [tlr_pkg::SEL_W-1:0] recv_sel_in,
	output logic      [tlr_pkg::SEL_W-1:0] drive_sel_out,
	output logic      [tlr_pkg::SEL_W-1:0] recv_sel_out,

	// Shared trigger line, open drain
	input  wire logic                      shared_trig_in,
	output logic                           shared_trig_out,
	output logic                           shared_trig_oe_out,

	// Internal trigger A
	input  wire logic                      internal_trigger_a_in,
	output logic                           internal_trigger_a_out,
	output logic                           internal_trigger_a_oe_out,

	// Internal trigger B
	input  wire logic                      internal_trigger_b_in,
	output logic                           internal_trigger_b_out,
	output logic                           internal_trigger_b_oe_out
);

	// ========================================
	// Drive selection
	logic [tlr_pkg::SEL_W-1:0] drive_sel_ff;
	logic [tlr_pkg::SEL_W-1:0] nxt_drive_sel;

	// A held load strobe reloads every cycle; a pulse is enough
	always_comb begin
		nxt_drive_sel = drive_sel_ff;
		if (cfg_load_in) begin
			nxt_drive_sel = drive_sel_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			drive_sel_ff <= tlr_pkg::SEL_NONE;
		end else begin
			drive_sel_ff <= nxt_drive_sel;
		end
	end

	// ========================================
	// Receive selection
	logic [tlr_pkg::SEL_W-1:0] recv_sel_ff;
	logic [tlr_pkg::SEL_W-1:0] nxt_recv_sel;

	// Shares the load strobe with the drive side but never its value
	always_comb begin
		nxt_recv_sel = recv_sel_ff;
		if (cfg_load_in) begin
			nxt_recv_sel = recv_sel_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			recv_sel_ff <= tlr_pkg::SEL_NONE;
		end else begin
			recv_sel_ff <= nxt_recv_sel;
		end
	end

	// ========================================
	// Lane inputs
	// Bit positions of both selections follow the lane order
	logic [tlr_pkg::SEL_W-1:0] trig_rx;

	assign trig_rx[tlr_pkg::LANE_A] = internal_trigger_a_in;
	assign trig_rx[tlr_pkg::LANE_B] = internal_trigger_b_in;

	// ========================================
	// Lane results
	logic [tlr_pkg::SEL_W-1:0] trig_drive;
	logic [tlr_pkg::SEL_W-1:0] recv_ok;

	// ========================================
	// Lanes
	// One lane per internal trigger; the core only combines their terms
	tlr_lane_if lane_if [tlr_pkg::SEL_W] ();

	genvar gi;
	generate
		for (gi = 0; gi < tlr_pkg::SEL_W; gi++) begin : g_lane
			// Selection bits and levels into the lane
			assign lane_if[gi].drive_en = drive_sel_ff[gi];
			assign lane_if[gi].recv_en  = recv_sel_ff[gi];
			assign lane_if[gi].line_rx  = shared_trig_in;
			assign lane_if[gi].trig_rx  = trig_rx[gi];

			// Lane terms back to the core
			assign trig_drive[gi]       = lane_if[gi].trig_drive;
			assign recv_ok[gi]          = lane_if[gi].recv_ok;

			tlr_lane u_lane (
				.lane_if (lane_if[gi])
			);
		end
	endgenerate

	// ========================================
	// Receive combine
	logic recv_any;
	logic recv_all;
	logic nxt_shared;

	// Receive is an AND of the selected triggers; no selection never asserts.
	// Selecting one trigger in both directions makes a loop through the
	// line that holds it asserted until reset or a new selection is loaded.
	always_comb begin
		recv_any   = |recv_sel_ff;
		recv_all   = &recv_ok;
		nxt_shared = recv_any & recv_all;
	end

	// ========================================
	// Shared line assertion
	logic shared_ff;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			shared_ff <= tlr_pkg::TRIG_RST;
		end else begin
			shared_ff <= nxt_shared;
		end
	end

	// ========================================
	// Internal trigger A drive
	logic trig_a_ff;
	logic nxt_trig_a;

	// One cycle from the line to the pin, as on the receive side
	always_comb begin
		nxt_trig_a = trig_drive[tlr_pkg::LANE_A];
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			trig_a_ff <= tlr_pkg::TRIG_RST;
		end else begin
			trig_a_ff <= nxt_trig_a;
		end
	end

	// ========================================
	// Internal trigger B drive
	logic trig_b_ff;
	logic nxt_trig_b;

	// Both lanes may drive at once: the OR forms on their own wires
	always_comb begin
		nxt_trig_b = trig_drive[tlr_pkg::LANE_B];
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			trig_b_ff <= tlr_pkg::TRIG_RST;
		end else begin
			trig_b_ff <= nxt_trig_b;
		end
	end

	// ========================================
	// Shared line pin
	// Open drain: the enable is high only while this side asserts the line
	always_comb begin
		shared_trig_out    = shared_ff;
		shared_trig_oe_out = shared_ff;
	end

	// ========================================
	// Internal trigger A pin
	// A lane that is not driving stays released for the other sources
	always_comb begin
		internal_trigger_a_out    = trig_a_ff;
		internal_trigger_a_oe_out = trig_a_ff;
	end

	// ========================================
	// Internal trigger B pin
	always_comb begin
		internal_trigger_b_out    = trig_b_ff;
		internal_trigger_b_oe_out = trig_b_ff;
	end

	// ========================================
	// Drive selection readback
	// Lets the controller read back the setting in force
	always_comb begin
		drive_sel_out = drive_sel_ff;
	end

	// ========================================
	// Receive selection readback
	always_comb begin
		recv_sel_out = recv_sel_ff;
	end

endmodule
